// ==== rtl/tbm_pkg.sv ====
// Package for the bias mode controller: mode codes, register layout, reset values, timing.
// Shared by the device end and the host end.
package tbm_pkg;
  // Power mode field codes
  localparam logic [1:0] TBM_MODE_ACTIVE = 2'h0;
  localparam logic [1:0] TBM_MODE_STARTUP = 2'h1;
  localparam logic [1:0] TBM_MODE_LOWPWR = 2'h2;
  localparam logic [1:0] TBM_MODE_SHUTDOWN = 2'h3;
  // Register select codes on the link
  localparam logic [3:0] TBM_REG_OUT0 = 4'h0;
  localparam logic [3:0] TBM_REG_BOOST = 4'h6;
  localparam logic [3:0] TBM_REG_ENABLE = 4'h7;
  localparam logic [3:0] TBM_REG_MODE = 4'h8;
  localparam int TBM_OUTPUTS = 6;
  // Reset values, off code, boost range and code scaling
  localparam logic [3:0] TBM_BOOST_RESET = 4'hF;
  localparam logic [5:0] TBM_ENABLE_RESET = 6'h00;
  localparam logic [7:0] TBM_CODE_RESET = 8'h00;
  localparam logic [7:0] TBM_CODE_OFF = 8'h00;
  localparam logic [3:0] TBM_BOOST_MIN_CODE = 4'h0;
  localparam logic [3:0] TBM_BOOST_MAX_CODE = 4'hF;
  localparam int TBM_BOOST_MIN_V = 9;
  localparam int TBM_CODE_STEP_MV = 188;
  localparam int TBM_CODE_STEPS = 128;
  // Startup settle time
  localparam int TBM_CLK_MHZ = 20;
  localparam int TBM_STARTUP_US = 180;
  localparam int TBM_STARTUP_CYC = TBM_STARTUP_US * TBM_CLK_MHZ;
  // Host command port offsets
  localparam logic [3:0] TBM_HOST_OUT0 = 4'h0;
  localparam logic [3:0] TBM_HOST_BOOST = 4'h6;
  localparam logic [3:0] TBM_HOST_ENABLE = 4'h7;
  localparam logic [3:0] TBM_HOST_MODE = 4'h8;
  localparam logic [3:0] TBM_HOST_STATUS = 4'h9;
  localparam logic [3:0] TBM_HOST_LAST = 4'hA;
  typedef enum logic [1:0] {TBM_ST_SHUTDOWN, TBM_ST_STARTUP, TBM_ST_ACTIVE, TBM_ST_LOWPWR} tbm_state_e;
endpackage : tbm_pkg

// ==== rtl/tbm_link_if.sv ====
// Link between host controller and bias mode device: register write port and mode status.
// Both ends on one clock.
`timescale 1ns/1ns
interface tbm_link_if;
  logic wr;
  logic [3:0] sel;
  logic [7:0] wdata;
  logic [1:0] mode;
  logic link_up;
  modport dev (input wr, sel, wdata, output mode, link_up);
  modport host (output wr, sel, wdata, input mode, link_up);
endinterface : tbm_link_if

// ==== rtl/tbm_device.sv ====
// Bias mode device: mode sequencer, six output codes, enables and boost level.
// Assumes io_supply_level and analog_supply are synchronous levels; rst is a plain clocked reset.
// Startup length is a cycle count, so STARTUP_CYC must follow the clock rate.
// Function
// - Six host-writable output code registers
// - Code maps linearly, 188 mV steps
// - Boost level is 4-bit, 9..24 V
// - Boost 0h lowest, Fh highest
// - Startup sets boost to 24 V code
// - Host keeps boost 2 V above outputs; tbm_host forwards boost writes unchecked
// - Code 00h disables output with pull-down
// - Shutdown: blocks off, outputs high impedance
// - Shutdown on supply power-up or IO low
// - Registers default after leaving shutdown
// - IO high: startup, reset, link, boost on
// - Startup request from active/low resets all
// - Startup moves to active by itself
// - Active: outputs off until individually enabled
// - Active accepts new codes anytime
// - Low power to active on request
// - Active to low power on request
// - Low power: link on, outputs hi-z, boost off
// - Low power keeps all registers
// - Mode field startup then active
// - Enable field resets all zeros
`timescale 1ns/1ns
module tbm_device import tbm_pkg::*; #(
  parameter int STARTUP_CYC = TBM_STARTUP_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Supply sense
  input wire logic analog_supply,
  input wire logic io_supply_level,
  // Link
  tbm_link_if.dev link,
  // Analog controls
  output logic [47:0] out_code,
  output logic [5:0] out_drive,
  output logic [5:0] out_pulldown,
  output logic [3:0] boost_level,
  output logic boost_on
);
  tbm_state_e state;
  logic [12:0] settle;
  logic [7:0] code [TBM_OUTPUTS];
  logic [5:0] enable;
  logic [1:0] mode_field;
  logic clear_regs;
  logic link_ok;
  logic mode_wr;
  logic req_startup;
  logic req_lowpwr;
  logic req_active;
  logic startup_done;
  logic drive_ok;

  // Registers are cleared while shutdown or startup holds
  assign clear_regs = (state == TBM_ST_SHUTDOWN) || (state == TBM_ST_STARTUP);
  assign link_ok = (state == TBM_ST_ACTIVE) || (state == TBM_ST_LOWPWR) || (state == TBM_ST_STARTUP);
  assign mode_wr = link.wr && (link.sel == TBM_REG_MODE) && link_ok;
  assign drive_ok = (state == TBM_ST_ACTIVE);

  // Request decode; only the two low bits carry a mode code, the rest are ignored
  assign req_startup = mode_wr && (link.wdata[1:0] == TBM_MODE_STARTUP);
  assign req_lowpwr = mode_wr && (link.wdata[1:0] == TBM_MODE_LOWPWR);
  assign req_active = mode_wr && (link.wdata[1:0] == TBM_MODE_ACTIVE);
  assign startup_done = (state == TBM_ST_STARTUP) && (settle == 13'(STARTUP_CYC - 1));

  // Startup settle counter; zero outside startup, so every entry waits the full time
  always_ff @(posedge clk) begin
    if (rst || (state != TBM_ST_STARTUP)) begin
      settle <= '0;
    end else if (!startup_done) begin
      settle <= settle + 13'h1;
    end
  end

  // Mode sequencer; a missing supply acts as reset at any time
  always_ff @(posedge clk) begin
    if (rst || !analog_supply || !io_supply_level) begin
      state <= TBM_ST_SHUTDOWN;
    end else begin
      unique case (state)
        TBM_ST_SHUTDOWN: begin
          state <= TBM_ST_STARTUP;
        end
        TBM_ST_STARTUP: begin
          if (startup_done) begin
            state <= TBM_ST_ACTIVE;
          end
        end
        TBM_ST_ACTIVE: begin
          if (req_startup) begin
            state <= TBM_ST_STARTUP;
          end else if (req_lowpwr) begin
            state <= TBM_ST_LOWPWR;
          end
          // Active again or shutdown codes are ignored
        end
        TBM_ST_LOWPWR: begin
          if (req_startup) begin
            state <= TBM_ST_STARTUP;
          end else if (req_active) begin
            state <= TBM_ST_ACTIVE;
          end
          // Any other request is ignored
        end
      endcase
    end
  end

  // Mode field follows the sequencer
  always_ff @(posedge clk) begin
    unique case (state)
      TBM_ST_STARTUP: mode_field <= TBM_MODE_STARTUP;
      TBM_ST_ACTIVE: mode_field <= TBM_MODE_ACTIVE;
      TBM_ST_LOWPWR: mode_field <= TBM_MODE_LOWPWR;
      TBM_ST_SHUTDOWN: mode_field <= TBM_MODE_SHUTDOWN;
    endcase
  end

  // Output codes; low power keeps taking writes so the host can stage values for the return
  always_ff @(posedge clk) begin
    if (rst || clear_regs) begin
      for (int i = 0; i < TBM_OUTPUTS; i++) begin
        code[i] <= TBM_CODE_RESET;
      end
    end else if (link.wr) begin
      for (int i = 0; i < TBM_OUTPUTS; i++) begin
        if (link.sel == TBM_REG_OUT0 + 4'(i)) begin
          code[i] <= link.wdata;
        end
      end
    end
  end

  // Output enable field; writes during startup are lost to the clear
  always_ff @(posedge clk) begin
    if (rst || clear_regs) begin
      enable <= TBM_ENABLE_RESET;
    end else if (link.wr && (link.sel == TBM_REG_ENABLE)) begin
      enable <= link.wdata[5:0];
    end
  end

  // Boost level; resets to the top rail so a fresh start never starves an output
  always_ff @(posedge clk) begin
    if (rst || clear_regs) begin
      boost_level <= TBM_BOOST_RESET;
    end else if (link.wr && (link.sel == TBM_REG_BOOST)) begin
      boost_level <= link.wdata[3:0];
    end
  end

  // Boost runs in startup and active only
  always_ff @(posedge clk) begin
    if (rst) begin
      boost_on <= 1'b0;
    end else begin
      boost_on <= (state == TBM_ST_STARTUP) || (state == TBM_ST_ACTIVE);
    end
  end

  // Code to level scaling is linear in the amplifier, so codes pass straight through
  always_ff @(posedge clk) begin
    if (rst) begin
      out_code <= '0;
    end else begin
      for (int i = 0; i < TBM_OUTPUTS; i++) begin
        out_code[i*8 +: 8] <= code[i];
      end
    end
  end

  // Drive only in active mode with enable set and a nonzero code
  always_ff @(posedge clk) begin
    if (rst) begin
      out_drive <= '0;
    end else begin
      for (int i = 0; i < TBM_OUTPUTS; i++) begin
        out_drive[i] <= drive_ok && enable[i] && (code[i] != TBM_CODE_OFF);
      end
    end
  end

  // Pull-down takes over an enabled output at code zero; with both low the pin floats
  always_ff @(posedge clk) begin
    if (rst) begin
      out_pulldown <= '0;
    end else begin
      for (int i = 0; i < TBM_OUTPUTS; i++) begin
        out_pulldown[i] <= drive_ok && enable[i] && (code[i] == TBM_CODE_OFF);
      end
    end
  end

  // Status back to host
  always_ff @(posedge clk) begin
    if (rst) begin
      link.link_up <= 1'b0;
    end else begin
      link.link_up <= link_ok;
    end
  end

  // Mode field is already a register, so it goes out as is
  assign link.mode = mode_field;
endmodule : tbm_device

// ==== rtl/tbm_host.sv ====
// Host end: turns software register writes into link writes and reports device mode.
// Assumes the device shares clk; software port as a plain strobe slave.
`timescale 1ns/1ns
module tbm_host import tbm_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Software port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  // Link
  tbm_link_if.host link
);
  logic [7:0] shadow [TBM_HOST_MODE + 4'h1];
  logic [7:0] last_mode;

  // Forward writes one cycle later; host must keep boost 2 V above outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      link.wr <= 1'b0;
      link.sel <= 4'h0;
      link.wdata <= 8'h00;
    end else begin
      link.wr <= wr_stb && (addr <= TBM_HOST_MODE);
      link.sel <= addr;
      link.wdata <= wdata;
    end
  end

  // Shadow of written values for readback
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i <= TBM_HOST_MODE; i++) begin
        shadow[i] <= 8'h00;
      end
      last_mode <= 8'h00;
    end else if (wr_stb && addr <= TBM_HOST_MODE) begin
      shadow[addr] <= wdata;
      if (addr == TBM_HOST_MODE) begin
        last_mode <= wdata;
      end
    end
  end

  // Read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd_stb) begin
      if (addr <= TBM_HOST_MODE) begin
        rdata <= shadow[addr];
      end else if (addr == TBM_HOST_STATUS) begin
        rdata <= {5'h00, link.link_up, link.mode};
      end else if (addr == TBM_HOST_LAST) begin
        rdata <= last_mode;
      end else begin
        rdata <= 8'h00;
      end
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule : tbm_host

// ==== tb/tbm_link_props.sv ====
// Checker on the link between host end and device end.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module tbm_link_props import tbm_pkg::*; #(
  parameter int STARTUP_CYC = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link signals
  input wire logic wr,
  input wire logic [3:0] sel,
  input wire logic [7:0] wdata,
  input wire logic [1:0] mode,
  input wire logic link_up
);
  localparam int WAIT_MAX = STARTUP_CYC + 20;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Mode request c seen while the field shows m
  sequence req(logic [1:0] m, logic [1:0] c);
    wr && sel == TBM_REG_MODE && wdata == {6'h00, c} && mode == m && link_up;
  endsequence
  // Startup holds a while, then clears by itself
  sequence in_startup;
    (mode == TBM_MODE_STARTUP) [*8];
  endsequence
  lp_entry_a: assert property (req(TBM_MODE_ACTIVE, TBM_MODE_LOWPWR) |-> ##2 mode == TBM_MODE_LOWPWR)
    else $error("low power entry missed");
  lp_cause_a: assert property (mode == TBM_MODE_LOWPWR && $past(mode) == TBM_MODE_ACTIVE
    |-> $past(wr, 2) && $past(wdata, 2) == {6'h00, TBM_MODE_LOWPWR}) else $error("low power without request");
  act_return_a: assert property (req(TBM_MODE_LOWPWR, TBM_MODE_ACTIVE) |-> ##2 mode == TBM_MODE_ACTIVE)
    else $error("return to active missed");
  reset_req_a: assert property ((req(TBM_MODE_ACTIVE, TBM_MODE_STARTUP) or
    req(TBM_MODE_LOWPWR, TBM_MODE_STARTUP)) |-> ##2 mode == TBM_MODE_STARTUP) else $error("startup request missed");
  bad_req_a: assert property (req(TBM_MODE_ACTIVE, TBM_MODE_SHUTDOWN) |-> ##2 mode == TBM_MODE_ACTIVE)
    else $error("illegal request changed mode");
  startup_done_a: assert property ($rose(mode == TBM_MODE_STARTUP)
    |-> in_startup ##[1:WAIT_MAX] mode == TBM_MODE_ACTIVE) else $error("startup did not finish");
  sd_exit_a: assert property ($past(mode) == TBM_MODE_SHUTDOWN && mode != TBM_MODE_SHUTDOWN
    |-> mode == TBM_MODE_STARTUP) else $error("shutdown left to wrong mode");
  lp_link_a: assert property (mode == TBM_MODE_LOWPWR |-> link_up)
    else $error("link down in low power");
endmodule : tbm_link_props

// ==== tb/tuner_bias_mode_control_tb_top.sv ====
// Bench: host end and device end joined by the link, driven from the software port.
// Assumes a 50 ns clock and a shortened startup count.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tuner_bias_mode_control_tb_top import tbm_pkg::*;;
  localparam int SCYC = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] sup = 2'h3;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [7:0] rdata, d;
  logic [47:0] out_code, exp;
  logic [5:0] out_drive, out_pulldown;
  logic [3:0] boost_level;
  logic boost_on;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  tbm_link_if link();
  tbm_device #(.STARTUP_CYC(SCYC)) i_tbm_device (.clk(clk), .rst(rst), .analog_supply(sup[0]),
    .io_supply_level(sup[1]), .link(link), .out_code(out_code), .out_drive(out_drive),
    .out_pulldown(out_pulldown), .boost_level(boost_level), .boost_on(boost_on));
  tbm_host i_tbm_host (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .link(link));
  tbm_link_props #(.STARTUP_CYC(SCYC)) i_tbm_link_props (.clk(clk), .rst(rst), .wr(link.wr),
    .sel(link.sel), .wdata(link.wdata), .mode(link.mode), .link_up(link.link_up));
  always #25 clk = ~clk;
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  // Hang guard: whole run needs a few hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      test_done();
    end
  end
  // Write, then let link, register and output stages settle
  task automatic wreg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask : wreg
  task automatic rreg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    d = rdata;
  endtask : rreg
  // Poll status until link up and active, then check power-on defaults
  task automatic wait_active();
    int i;
    i = 0;
    d = 8'h00;
    while (d !== 8'h04 && i < 200) begin
      rreg(TBM_HOST_STATUS);
      i++;
    end
    `CHK("status", 8'h04, d)
    `CHK("boost", TBM_BOOST_RESET, boost_level)
    `CHK("codes", 48'h0, out_code)
    `CHK("drive", 6'h00, out_drive)
    `CHK("pulldown", 6'h00, out_pulldown)
    `CHK("boost on", 1'b1, boost_on)
  endtask : wait_active
  task automatic t_codes();
    // Lowest boost only while every output sits at zero, to keep the 2 V headroom
    wreg(TBM_HOST_BOOST, {4'h0, TBM_BOOST_MIN_CODE});
    `CHK("boost min", TBM_BOOST_MIN_CODE, boost_level)
    wreg(TBM_HOST_BOOST, {4'h0, TBM_BOOST_MAX_CODE});
    `CHK("boost max", TBM_BOOST_MAX_CODE, boost_level)
    for (int i = 0; i < TBM_OUTPUTS; i++) begin
      wreg(TBM_HOST_OUT0 + 4'(i), 8'(i * 21));
      exp[i * 8 +: 8] = 8'(i * 21);
    end
    `CHK("codes", exp, out_code)
    `CHK("off until enabled", 6'h00, out_drive)
    wreg(TBM_HOST_ENABLE, 8'h3E);
    `CHK("drive", 6'h3E, out_drive)
    wreg(TBM_HOST_ENABLE, 8'h3F);
    `CHK("zero code pulldown", 6'h01, out_pulldown)
    wreg(TBM_HOST_OUT0 + 4'h1, 8'h50);
    exp[15:8] = 8'h50;
    `CHK("live code", exp, out_code)
    $display("t_codes done");
  endtask : t_codes
  task automatic t_lowpwr();
    wreg(TBM_HOST_MODE, {6'h00, TBM_MODE_SHUTDOWN});
    rreg(TBM_HOST_STATUS);
    `CHK("illegal request", 8'h04, d)
    wreg(TBM_HOST_MODE, {6'h00, TBM_MODE_LOWPWR});
    rreg(TBM_HOST_STATUS);
    `CHK("lp status", 8'h06, d)
    `CHK("lp drive", 6'h00, out_drive)
    `CHK("lp pulldown", 6'h00, out_pulldown)
    `CHK("lp boost off", 1'b0, boost_on)
    wreg(TBM_HOST_BOOST, 8'h0D);
    wreg(TBM_HOST_MODE, {6'h00, TBM_MODE_ACTIVE});
    `CHK("kept codes", exp, out_code)
    `CHK("back to active", 6'h3E, out_drive)
    `CHK("boost mid", 4'hD, boost_level)
    $display("t_lowpwr done");
  endtask : t_lowpwr
  task automatic t_resets();
    wreg(TBM_HOST_MODE, {6'h00, TBM_MODE_STARTUP});
    rreg(TBM_HOST_STATUS);
    `CHK("startup status", 8'h05, d)
    wait_active();
    // Same full reset asked for from low power, with a code staged there first
    wreg(TBM_HOST_MODE, {6'h00, TBM_MODE_LOWPWR});
    wreg(TBM_HOST_OUT0 + 4'h3, 8'h30);
    wreg(TBM_HOST_MODE, {6'h00, TBM_MODE_STARTUP});
    wait_active();
    // Drop each supply in turn with an output driven
    for (int s = 0; s < 2; s++) begin
      wreg(TBM_HOST_OUT0 + 4'h2, 8'h40);
      wreg(TBM_HOST_ENABLE, 8'h04);
      `CHK("drive before drop", 6'h04, out_drive)
      @(posedge clk) sup[s] <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      `CHK("sd drive", 6'h00, out_drive)
      `CHK("sd boost", 1'b0, boost_on)
      rreg(TBM_HOST_STATUS);
      `CHK("sd status", 8'h03, d)
      @(posedge clk) sup[s] <= 1'b1;
      wait_active();
    end
    $display("t_resets done");
  endtask : t_resets
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    wait_active();
    t_codes();
    t_lowpwr();
    t_resets();
    test_done();
  end
endmodule : tuner_bias_mode_control_tb_top
